// *** hex_char_codec.v ***
`timescale 1ns/1ns
// converts between a 4-bit value and one ascii hex character
module hex_char_codec (
  input wire [7:0] char_i, // incoming character
  output reg [3:0] nibble_o, // decoded value
  output reg char_ok_o, // high when char_i is a hex digit
  input wire [3:0] nibble_i, // value to encode
  output reg [7:0] char_o // upper-case hex character
);

  // decode: digits, upper and lower case letters
  always @*
  begin
    nibble_o = 4'h0;
    char_ok_o = 1'b0;
    if (char_i >= 8'h30 && char_i <= 8'h39)
    begin
      nibble_o = char_i[3:0];
      char_ok_o = 1'b1;
    end
    else if ((char_i >= 8'h41 && char_i <= 8'h46) || (char_i >= 8'h61 && char_i <= 8'h66))
    begin
      nibble_o = char_i[3:0] + 4'h9;
      char_ok_o = 1'b1;
    end
  end

  // encode: 0-9 then A-F
  always @*
  begin
    if (nibble_i < 4'hA)
      char_o = {4'h3, nibble_i};
    else
      char_o = {4'h4, nibble_i - 4'h9};
  end

endmodule

// *** host_model.sv ***
`timescale 1ns/1ns
module host_model (
  input wire mclk_i, // clock
  input wire rsp_error_i, // error
  input wire [7:0] rsp_data_i, // answer
  output reg cmd_valid_o = 1'b0, // command
  output reg cmd_write_o = 1'b0, // write
  output reg [2:0] cmd_sel_o = 3'h0, // select
  output reg [7:0] cmd_data_o = 8'h00, // data
  output reg sanitize_o = 1'b0, // sanitize
  output reg save_o = 1'b0 // save
);
  // clamp byte as want / (full * 1.1) * 256
  function [7:0] clamp_code(input integer want, input integer full);
    clamp_code = want * 2560 / (full * 11);
  endfunction
  // policy as one hex character, lower case above nine
  function [7:0] hex_char(input [3:0] n);
    hex_char = n < 4'hA ? 8'h30 + n : 8'h57 + n;
  endfunction
  // request held over one taking edge, answer read a cycle on
  task xfer(input w, input [2:0] s, input [7:0] d, output e, output [7:0] r);
    begin
      cmd_valid_o = 1'b1;
      cmd_write_o = w;
      cmd_sel_o = s;
      cmd_data_o = d;
      @(negedge mclk_i);
      e = rsp_error_i;
      r = rsp_data_i;
    end
  endtask
  // released select and data lines never keep the last value
  task idle;
    begin
      cmd_valid_o = 1'b0;
      cmd_sel_o = ~cmd_sel_o;
      cmd_data_o = ~cmd_data_o;
    end
  endtask
  // one-cycle save or sanitize pulse
  task pulse(input s);
    begin
      if (s)
        save_o = 1'b1;
      else
        sanitize_o = 1'b1;
      @(negedge mclk_i);
      save_o = 1'b0;
      sanitize_o = 1'b0;
    end
  endtask
endmodule

// *** lcs_monitor.sv ***
`timescale 1ns/1ns
`include "limit_clamp_regs.vh"
module lcs_monitor (
  input wire mclk_i, // clock
  input wire reset_n_i, // reset
  input wire cmd_valid_i, // command
  input wire cmd_write_i, // write
  input wire [2:0] cmd_sel_i, // select
  input wire [7:0] cmd_data_i, // data
  input wire sanitize_i, // sanitize
  input wire save_diag_i, // save
  input wire output_on_i, // on
  input wire current_mode_i, // mode
  input wire [7:0] current_error_policy_i, // policy
  input wire [7:0] voltage_error_policy_i, // policy
  input wire [7:0] volt_limit_dac_o, // dac
  input wire [7:0] curr_limit_dac_o, // dac
  input wire [1:0] volt_source_o, // source
  input wire [1:0] curr_source_o, // source
  input wire rsp_valid_o, // answer
  input wire rsp_error_o, // error
  input wire save_strobe_o // commit
);
  reg [3:0] pol;
  reg [4:0] hx;
  wire off_v = !output_on_i && !current_mode_i;
  wire off_c = !output_on_i && current_mode_i;
  // hex character decode, hx[4] marks a digit
  always @*
  begin
    hx = 5'h00;
    if (cmd_data_i >= 8'h30 && cmd_data_i <= 8'h39)
      hx = {1'b1, cmd_data_i[3:0]};
    if ((cmd_data_i | 8'h20) >= 8'h61 && (cmd_data_i | 8'h20) <= 8'h66)
      hx = {1'b1, cmd_data_i[3:0] + 4'h9};
  end
  // shadow of the output-off policy field
  always @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      pol <= 4'h0;
    else if (sanitize_i)
      pol <= 4'h0;
    else if (cmd_valid_i && cmd_write_i && cmd_sel_i == 3'h4 && hx[4])
      pol <= hx[3:0];
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  answer_pulse_a:
    assert property (cmd_valid_i |=> rsp_valid_o) else $error("no answer");
  bad_hex_a:
    assert property (cmd_valid_i && cmd_write_i && cmd_sel_i == 3'h4 && !hx[4]
      |=> rsp_error_o) else $error("bad hex accepted");
  zero_off_a:
    assert property (!output_on_i && pol == 4'h0 |=> volt_limit_dac_o == 8'h00
      && curr_limit_dac_o == 8'h00) else $error("off dacs not zero");
  volt_max_a:
    assert property (off_v && pol[0] |=> volt_limit_dac_o == `DAC_MAX_CODE)
      else $error("volt not max");
  curr_max_a:
    assert property (off_c && pol[1] |=> curr_limit_dac_o == `DAC_MAX_CODE)
      else $error("curr not max");
  volt_clamp_a:
    assert property (!output_on_i && pol[2] && !(off_v && pol[0])
      |=> volt_source_o == `SRC_CLAMP) else $error("volt clamp missing");
  curr_clamp_a:
    assert property (!output_on_i && pol[3] && !(off_c && pol[1])
      |=> curr_source_o == `SRC_CLAMP) else $error("curr clamp missing");
  on_curr_a:
    assert property (output_on_i && !current_mode_i && current_error_policy_i[7]
      |=> curr_source_o == `SRC_CLAMP) else $error("on curr clamp missing");
  on_volt_a:
    assert property (output_on_i && current_mode_i && voltage_error_policy_i[7]
      |=> volt_source_o == `SRC_CLAMP) else $error("on volt clamp missing");
  sanitize_zero_a:
    assert property (sanitize_i ##1 !output_on_i |=> curr_limit_dac_o == 8'h00)
      else $error("sanitize kept policy");
  save_pulse_a:
    assert property (save_diag_i |=> save_strobe_o) else $error("no commit");
  answer_once_a:
    assert property (!cmd_valid_i |=> !rsp_valid_o) else $error("stray answer");
  commit_once_a:
    assert property (!save_diag_i |=> !save_strobe_o) else $error("stray commit");
  cover property (off_v && pol[0] && pol[2]);
  cover property (output_on_i && current_mode_i && voltage_error_policy_i[7]);
  cover property (sanitize_i);
endmodule
bind limit_dac_clamp_select lcs_monitor i_lcs_monitor (.*);

// *** limit_clamp_regs.vh ***
`ifndef LIMIT_CLAMP_REGS_VH
`define LIMIT_CLAMP_REGS_VH

// register selects on the setup command port
`define SEL_OFF_STATE_CURRENT_CLAMP 3'h0
`define SEL_OFF_STATE_VOLTAGE_CLAMP 3'h1
`define SEL_ON_STATE_CURRENT_CLAMP 3'h2
`define SEL_ON_STATE_VOLTAGE_CLAMP 3'h3
`define SEL_OUTPUT_OFF_POLICY 3'h4

// factory defaults
`define CLAMP_RESET 8'h00
`define POLICY_RESET 4'h0

// output-off policy field bit positions
`define POLICY_VOLT_MAX_BIT 0
`define POLICY_CURR_MAX_BIT 1
`define POLICY_VOLT_CLAMP_BIT 2
`define POLICY_CURR_CLAMP_BIT 3

// error-policy bit that enables the on-state clamp
`define ERR_POLICY_FIXED_LIMIT_BIT 7

// dac codes
`define DAC_MAX_CODE 8'hFF
`define DAC_ZERO_CODE 8'h00

// source codes reported per limit
`define SRC_SETPOINT 2'h0
`define SRC_ZERO 2'h1
`define SRC_CLAMP 2'h2
`define SRC_MAX 2'h3

// layout of the saved image
`define IMG_OFF_CURR_LSB 0
`define IMG_OFF_VOLT_LSB 8
`define IMG_ON_CURR_LSB 16
`define IMG_ON_VOLT_LSB 24
`define IMG_POLICY_LSB 32

`endif

// *** limit_code_pick.v ***
`timescale 1ns/1ns
`include "limit_clamp_regs.vh"
// chooses the code for one limit dac
module limit_code_pick (
  input wire output_on_i, // output enabled
  input wire max_en_i, // off-state maximum option applies
  input wire off_clamp_en_i, // off-state clamp option applies
  input wire off_zero_i, // policy field is zero
  input wire on_clamp_en_i, // on-state clamp applies
  input wire [7:0] off_clamp_i, // off-state clamp byte
  input wire [7:0] on_clamp_i, // on-state clamp byte
  input wire [7:0] setpoint_i, // normal setpoint path code
  output reg [7:0] code_o, // chosen dac code
  output reg [1:0] source_o // which source was chosen
);

  // maximum beats clamp when both are set
  always @*
  begin
    code_o = setpoint_i;
    source_o = `SRC_SETPOINT;
    if (output_on_i)
    begin
      if (on_clamp_en_i)
      begin
        code_o = on_clamp_i;
        source_o = `SRC_CLAMP;
      end
    end
    else if (off_zero_i)
    begin
      code_o = `DAC_ZERO_CODE;
      source_o = `SRC_ZERO;
    end
    else if (max_en_i)
    begin
      code_o = `DAC_MAX_CODE;
      source_o = `SRC_MAX;
    end
    else if (off_clamp_en_i)
    begin
      code_o = off_clamp_i;
      source_o = `SRC_CLAMP;
    end
  end

endmodule

// *** limit_dac_clamp_select.v ***
// What this block does
// - off, voltage mode: current clamp per policy
// - off, current mode: voltage clamp per policy
// - on, voltage mode: current clamp if bit7
// - on, current mode: voltage clamp if bit7
// - all four clamp bytes reset to zero
// - clamp readback returns the stored byte
// - policy zero forces both dacs zero when off
// - bit0 sets voltage dac max, off voltage mode
// - bit1 sets current dac max, off current mode
// - bit2 drives voltage clamp while output off
// - bit3 drives current clamp while output off
// - maximum option overrides the clamp option
// - sanitize command clears the policy field
// - policy is four bits, one hex character
// - save command commits setup variables
// - current error bit7 fixes current limit on, voltage mode only
// - voltage error bit7 fixes voltage limit on, current mode only
`timescale 1ns/1ns
`include "limit_clamp_regs.vh"
module limit_dac_clamp_select (
  input wire mclk_i, // controller clock, 25 MHz
  input wire reset_n_i, // asynchronous reset, active low
  input wire cmd_valid_i, // setup command present this cycle
  input wire cmd_write_i, // 1 = write, 0 = readback
  input wire [2:0] cmd_sel_i, // register select
  input wire [7:0] cmd_data_i, // clamp byte or policy hex character
  input wire sanitize_i, // security sanitize command pulse
  input wire save_diag_i, // save diagnostic setup command pulse
  input wire output_on_i, // channel output is on
  input wire current_mode_i, // 1 = current mode, 0 = voltage mode
  input wire [7:0] current_error_policy_i, // current error-policy byte
  input wire [7:0] voltage_error_policy_i, // voltage error-policy byte
  input wire [7:0] volt_setpoint_i, // normal voltage-limit code
  input wire [7:0] curr_setpoint_i, // normal current-limit code
  output reg [7:0] volt_limit_dac_o, // voltage-limit dac code
  output reg [7:0] curr_limit_dac_o, // current-limit dac code
  output reg [1:0] volt_source_o, // source of voltage-limit code
  output reg [1:0] curr_source_o, // source of current-limit code
  output reg rsp_valid_o, // answer pulse, one cycle
  output reg rsp_error_o, // bad select or bad hex character
  output reg [7:0] rsp_data_o, // readback byte or hex character
  output reg save_strobe_o, // commit pulse to non-volatile store
  output reg [35:0] save_image_o // setup snapshot to commit
);

  // stored setup variables
  reg [7:0] off_state_current_clamp;
  reg [7:0] off_state_voltage_clamp;
  reg [7:0] on_state_current_clamp;
  reg [7:0] on_state_voltage_clamp;
  reg [3:0] output_off_policy;

  // command decode results
  reg sel_known;
  reg [7:0] read_data;
  wire [3:0] policy_nibble;
  wire policy_char_ok;
  wire [7:0] policy_char;
  wire wr_hit;
  wire wr_policy_ok;
  wire wr_error;

  // mode and enable terms
  wire voltage_mode;
  wire policy_zero;
  wire volt_max_en;
  wire curr_max_en;
  wire volt_clamp_en;
  wire curr_clamp_en;
  wire volt_on_clamp_en;
  wire curr_on_clamp_en;

  // chosen codes before the output flops
  wire [7:0] next_volt_code;
  wire [7:0] next_curr_code;
  wire [1:0] next_volt_source;
  wire [1:0] next_curr_source;

  // per-limit buses for the code pickers
  // bit or byte 0 belongs to the voltage limit, 1 to the current limit
  wire [1:0] lim_max_en;
  wire [1:0] lim_clamp_en;
  wire [1:0] lim_on_clamp_en;
  wire [15:0] lim_off_clamp;
  wire [15:0] lim_on_clamp;
  wire [15:0] lim_setpoint;
  wire [15:0] lim_code;
  wire [3:0] lim_source;

  // policy field travels as one hex character both ways
  // lower-case letters are accepted on write, readback is always upper case
  hex_char_codec u_policy_codec (
    .char_i(cmd_data_i),
    .nibble_o(policy_nibble),
    .char_ok_o(policy_char_ok),
    .nibble_i(output_off_policy),
    .char_o(policy_char)
  );

  // select decode
  // selects 5 to 7 are unmapped; they change nothing and answer with an error
  always @*
  begin
    sel_known = 1'b1;
    case (cmd_sel_i)
      `SEL_OFF_STATE_CURRENT_CLAMP: sel_known = 1'b1;
      `SEL_OFF_STATE_VOLTAGE_CLAMP: sel_known = 1'b1;
      `SEL_ON_STATE_CURRENT_CLAMP: sel_known = 1'b1;
      `SEL_ON_STATE_VOLTAGE_CLAMP: sel_known = 1'b1;
      `SEL_OUTPUT_OFF_POLICY: sel_known = 1'b1;
      default: sel_known = 1'b0;
    endcase
  end

  // write qualification
  // a refused policy character must not reach the field, only the error flag
  assign wr_hit = cmd_valid_i & cmd_write_i & sel_known;
  assign wr_policy_ok = wr_hit & (cmd_sel_i == `SEL_OUTPUT_OFF_POLICY) & policy_char_ok;
  assign wr_error = cmd_valid_i & (~sel_known |
    (cmd_write_i & (cmd_sel_i == `SEL_OUTPUT_OFF_POLICY) & ~policy_char_ok));

  // clamp byte storage, zero by default
  // every byte is a legal dac code, so clamp writes are never refused
  // the four bytes come up zero, matching their factory default
  always @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      off_state_current_clamp <= `CLAMP_RESET;
      off_state_voltage_clamp <= `CLAMP_RESET;
      on_state_current_clamp <= `CLAMP_RESET;
      on_state_voltage_clamp <= `CLAMP_RESET;
    end
    else if (wr_hit)
    begin
      case (cmd_sel_i)
        `SEL_OFF_STATE_CURRENT_CLAMP: off_state_current_clamp <= cmd_data_i;
        `SEL_OFF_STATE_VOLTAGE_CLAMP: off_state_voltage_clamp <= cmd_data_i;
        `SEL_ON_STATE_CURRENT_CLAMP: on_state_current_clamp <= cmd_data_i;
        `SEL_ON_STATE_VOLTAGE_CLAMP: on_state_voltage_clamp <= cmd_data_i;
        default: off_state_current_clamp <= off_state_current_clamp;
      endcase
    end
  end

  // policy field; sanitize wins over a write in the same cycle
  // sanitize must win so a stale write cannot survive a clear
  // a refused character leaves the field as it was
  always @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      output_off_policy <= `POLICY_RESET;
    else if (sanitize_i)
      output_off_policy <= `POLICY_RESET;
    else if (wr_policy_ok)
      output_off_policy <= policy_nibble;
  end

  // readback mux: clamps as a raw byte, policy as a hex character
  // unmapped selects read back as zero
  always @*
  begin
    case (cmd_sel_i)
      `SEL_OFF_STATE_CURRENT_CLAMP: read_data = off_state_current_clamp;
      `SEL_OFF_STATE_VOLTAGE_CLAMP: read_data = off_state_voltage_clamp;
      `SEL_ON_STATE_CURRENT_CLAMP: read_data = on_state_current_clamp;
      `SEL_ON_STATE_VOLTAGE_CLAMP: read_data = on_state_voltage_clamp;
      `SEL_OUTPUT_OFF_POLICY: read_data = policy_char;
      default: read_data = 8'h00;
    endcase
  end

  // answer one cycle after each command
  // rsp_data_o holds the last answer until the next command arrives
  // rsp_error_o stands for the answer cycle only
  always @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rsp_valid_o <= 1'b0;
      rsp_error_o <= 1'b0;
      rsp_data_o <= 8'h00;
    end
    else
    begin
      rsp_valid_o <= cmd_valid_i;
      rsp_error_o <= wr_error;
      if (cmd_valid_i && !cmd_write_i)
        rsp_data_o <= read_data;
      else if (cmd_valid_i)
        rsp_data_o <= 8'h00;
    end
  end

  // commit snapshot of the setup variables on save
  // the image carries the values from before any write in the same cycle
  // a write in the same cycle lands in the next save, not this one
  always @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      save_strobe_o <= 1'b0;
      save_image_o <= 36'h0_0000_0000;
    end
    else
    begin
      save_strobe_o <= save_diag_i;
      if (save_diag_i)
      begin
        save_image_o[`IMG_OFF_CURR_LSB +: 8] <= off_state_current_clamp;
        save_image_o[`IMG_OFF_VOLT_LSB +: 8] <= off_state_voltage_clamp;
        save_image_o[`IMG_ON_CURR_LSB +: 8] <= on_state_current_clamp;
        save_image_o[`IMG_ON_VOLT_LSB +: 8] <= on_state_voltage_clamp;
        save_image_o[`IMG_POLICY_LSB +: 4] <= output_off_policy;
      end
    end
  end

  // mode terms
  // a zero policy field forces both dacs to zero while off, ahead of every option
  assign voltage_mode = ~current_mode_i;
  assign policy_zero = (output_off_policy == `POLICY_RESET);

  // off-state options; maximum only applies in its own mode
  assign volt_max_en = output_off_policy[`POLICY_VOLT_MAX_BIT] & voltage_mode;
  assign curr_max_en = output_off_policy[`POLICY_CURR_MAX_BIT] & current_mode_i;
  // clamp enables follow the policy map
  // either clamp applies in both modes while the output is off
  // the bit 2 / bit 3 map is used because the clamp bit positions disagree
  assign volt_clamp_en = output_off_policy[`POLICY_VOLT_CLAMP_BIT];
  assign curr_clamp_en = output_off_policy[`POLICY_CURR_CLAMP_BIT];

  // on-state fixed limits from the error-policy bytes
  // only bit 7 of each error-policy byte is used by this block
  // the fixed limit only guards the quantity that the mode does not regulate
  assign curr_on_clamp_en = voltage_mode &
    current_error_policy_i[`ERR_POLICY_FIXED_LIMIT_BIT];
  assign volt_on_clamp_en = current_mode_i &
    voltage_error_policy_i[`ERR_POLICY_FIXED_LIMIT_BIT];

  // per-limit operands, voltage limit low, current limit high
  assign lim_max_en = {curr_max_en, volt_max_en};
  assign lim_clamp_en = {curr_clamp_en, volt_clamp_en};
  assign lim_on_clamp_en = {curr_on_clamp_en, volt_on_clamp_en};
  assign lim_off_clamp = {off_state_current_clamp, off_state_voltage_clamp};
  assign lim_on_clamp = {on_state_current_clamp, on_state_voltage_clamp};
  assign lim_setpoint = {curr_setpoint_i, volt_setpoint_i};

  // one code picker per limit dac: zero, then maximum, then clamp, then setpoint
  genvar lim;
  generate
    for (lim = 0; lim < 2; lim = lim + 1)
    begin : g_limit
      limit_code_pick u_pick (
        .output_on_i(output_on_i),
        .max_en_i(lim_max_en[lim]),
        .off_clamp_en_i(lim_clamp_en[lim]),
        .off_zero_i(policy_zero),
        .on_clamp_en_i(lim_on_clamp_en[lim]),
        .off_clamp_i(lim_off_clamp[8*lim +: 8]),
        .on_clamp_i(lim_on_clamp[8*lim +: 8]),
        .setpoint_i(lim_setpoint[8*lim +: 8]),
        .code_o(lim_code[8*lim +: 8]),
        .source_o(lim_source[2*lim +: 2])
      );
    end
  endgenerate

  // split the picked codes back out per limit
  assign next_volt_code = lim_code[7:0];
  assign next_curr_code = lim_code[15:8];
  assign next_volt_source = lim_source[1:0];
  assign next_curr_source = lim_source[3:2];

  // registered dac codes; max beats clamp, else setpoint path
  // the dac pins only ever see a settled, registered code
  // sources are reported alongside so a monitor can tell zero from a zero clamp
  always @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      volt_limit_dac_o <= `DAC_ZERO_CODE;
      curr_limit_dac_o <= `DAC_ZERO_CODE;
      volt_source_o <= `SRC_ZERO;
      curr_source_o <= `SRC_ZERO;
    end
    else
    begin
      volt_limit_dac_o <= next_volt_code;
      curr_limit_dac_o <= next_curr_code;
      volt_source_o <= next_volt_source;
      curr_source_o <= next_curr_source;
    end
  end

endmodule

// *** tb_top.sv ***
`timescale 1ns/1ns
`define CHK(g, e) \
  begin \
    n_tests = n_tests + 1; \
    if ((g) !== (e)) \
    begin \
      n_fail = n_fail + 1; \
      $display("[ERR] %0t got %h exp %h", $time, g, e); \
    end \
  end
module tb_top;
  reg mclk_i, reset_n_i, output_on_i, current_mode_i, err;
  reg [7:0] current_error_policy_i, voltage_error_policy_i, rd, ev, ec;
  reg [7:0] volt_setpoint_i, curr_setpoint_i;
  reg [7:0] cl [0:3];
  wire cmd_valid_i, cmd_write_i, sanitize_i, save_diag_i;
  wire rsp_valid_o, rsp_error_o, save_strobe_o;
  wire [2:0] cmd_sel_i;
  wire [7:0] cmd_data_i, volt_limit_dac_o, curr_limit_dac_o, rsp_data_o;
  wire [1:0] volt_source_o, curr_source_o;
  wire [35:0] save_image_o;
  integer n_fail = 0, n_tests = 0, cyc = 0, p;
  limit_dac_clamp_select i_limit_dac_clamp_select (.*);
  host_model i_host_model (.mclk_i(mclk_i), .rsp_error_i(rsp_error_o),
    .rsp_data_i(rsp_data_o), .cmd_valid_o(cmd_valid_i), .cmd_write_o(cmd_write_i),
    .cmd_sel_o(cmd_sel_i), .cmd_data_o(cmd_data_i), .sanitize_o(sanitize_i),
    .save_o(save_diag_i));
  // one command and its answer
  task cmd(input w, input [2:0] s, input [7:0] d, input [7:0] xd, input xe);
    begin
      i_host_model.xfer(w, s, d, err, rd);
      `CHK(rsp_valid_o, 1'b1)
      `CHK(err, xe)
      `CHK(rd, xd)
    end
  endtask
  // let the dac registers follow, then compare
  task look(input [7:0] xv, input [7:0] xc);
    begin
      i_host_model.idle;
      @(negedge mclk_i);
      `CHK(volt_limit_dac_o, xv)
      `CHK(curr_limit_dac_o, xc)
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial
  begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  // hang guard
  always @(posedge mclk_i)
  begin
    cyc = cyc + 1;
    if (cyc == 2000)
    begin
      n_fail = n_fail + 1;
      print_verdict;
    end
  end
  initial
  begin
    reset_n_i = 1'b0;
    output_on_i = 1'b0;
    current_mode_i = 1'b0;
    current_error_policy_i = 8'h00;
    voltage_error_policy_i = 8'h00;
    volt_setpoint_i = 8'h5A;
    curr_setpoint_i = 8'hA5;
    repeat (10) @(negedge mclk_i);
    reset_n_i = 1'b1;
    @(negedge mclk_i);
    for (p = 0; p < 4; p = p + 1)
      cmd(1'b0, p[2:0], 8'h00, 8'h00, 1'b0);
    cmd(1'b0, 3'h4, 8'h00, 8'h30, 1'b0);
    look(8'h00, 8'h00);
    $display("test reset done");
    cl[0] = i_host_model.clamp_code(550, 1000);
    cl[1] = i_host_model.clamp_code(220, 1000);
    cl[2] = i_host_model.clamp_code(440, 1000);
    cl[3] = i_host_model.clamp_code(330, 1000);
    // back-to-back writes, then readbacks
    for (p = 0; p < 8; p = p + 1)
      cmd(!p[2], p[1:0], cl[p[1:0]], p[2] ? cl[p[1:0]] : 8'h00, 1'b0);
    $display("test clamps done");
    // every policy in both modes, output off
    for (p = 0; p < 32; p = p + 1)
    begin
      current_mode_i = p[4];
      cmd(1'b1, 3'h4, i_host_model.hex_char(p[3:0]), 8'h00, 1'b0);
      cmd(1'b0, 3'h4, 8'h00, p[3:0] < 10 ? 8'h30 + p[3:0] : 8'h37 + p[3:0], 1'b0);
      ev = p[0] && !p[4] ? 8'hFF : p[2] ? cl[1] : 8'h5A;
      ec = p[1] && p[4] ? 8'hFF : p[3] ? cl[0] : 8'hA5;
      if (p[3:0] == 4'h0)
      begin
        ev = 8'h00;
        ec = 8'h00;
      end
      look(ev, ec);
    end
    $display("test policy done");
    // output on: only bit 7 of the error bytes counts
    output_on_i = 1'b1;
    for (p = 0; p < 8; p = p + 1)
    begin
      current_mode_i = p[0];
      current_error_policy_i = {p[1], 7'h7F};
      voltage_error_policy_i = {p[2], 7'h7F};
      look(p[0] && p[2] ? cl[3] : 8'h5A, !p[0] && p[1] ? cl[2] : 8'hA5);
    end
    $display("test on done");
    // refusals, save image, sanitize
    output_on_i = 1'b0;
    cmd(1'b1, 3'h5, 8'h12, 8'h00, 1'b1);
    cmd(1'b0, 3'h7, 8'h00, 8'h00, 1'b1);
    cmd(1'b1, 3'h4, 8'h63, 8'h00, 1'b0);
    cmd(1'b1, 3'h4, 8'h47, 8'h00, 1'b1);
    i_host_model.idle;
    i_host_model.pulse(1'b1);
    `CHK(save_strobe_o, 1'b1)
    `CHK(save_image_o, {4'hC, cl[3], cl[2], cl[1], cl[0]})
    cmd(1'b0, 3'h4, 8'h00, 8'h43, 1'b0);
    i_host_model.idle;
    i_host_model.pulse(1'b0);
    cmd(1'b0, 3'h4, 8'h00, 8'h30, 1'b0);
    look(8'h00, 8'h00);
    $display("test misc done");
    // a second reset in mid-run puts the on-state clamps back to zero
    reset_n_i = 1'b0;
    @(negedge mclk_i);
    reset_n_i = 1'b1;
    cmd(1'b0, 3'h3, 8'h00, 8'h00, 1'b0);
    cmd(1'b0, 3'h2, 8'h00, 8'h00, 1'b0);
    $display("test second reset done");
    print_verdict;
  end
endmodule
